/* logic/sample_buffer_pkg.sv */
// Constants for the sample buffer status block and its register map.
package sample_buffer_pkg;

    // ==========================================================
    // Register word indices; byte address is four times the index
    // ==========================================================
    localparam logic [7:0] IDX_STATUS = 8'h0B;
    localparam logic [7:0] IDX_SETUP_FIRST = 8'h12;
    localparam logic [7:0] IDX_SETUP_SECOND = 8'h13;
    localparam logic [7:0] IDX_DATA_XY = 8'h14;
    localparam logic [7:0] IDX_DATA_Z = 8'h15;
    localparam logic [7:0] IDX_IRQ_STATUS = 8'h16;
    localparam logic [7:0] IDX_IRQ_MASK = 8'h17;
    localparam int WORD_SHIFT = 2;

    // ==========================================================
    // Field layouts
    // ==========================================================
    localparam int ST_WMRK_BIT = 7;
    localparam int ST_OVF_BIT = 6;
    localparam int CNT_W = 6;
    localparam int MODE_LSB = 0;
    localparam int MODE_W = 2;
    localparam int TYPE_BIT = 2;
    localparam int LEVEL_W = 6;
    localparam int FLUSH_BIT = 7;
    localparam int AXIS_W = 12;
    localparam int SAMPLE_W = 3 * AXIS_W;
    localparam int IRQ_W = 2;
    localparam int IRQ_WMRK_BIT = 0;
    localparam int IRQ_OVF_BIT = 1;

    // ==========================================================
    // Encodings and reset values
    // ==========================================================
    localparam logic [1:0] MODE_OFF = 2'h0;
    localparam logic TYPE_FIFO = 1'b0;
    localparam logic TYPE_LIFO = 1'b1;
    localparam logic [1:0] MODE_RESET = 2'h0;
    localparam logic [5:0] LEVEL_RESET = 6'h00;
    localparam logic [1:0] IRQ_MASK_RESET = 2'h0;

endpackage : sample_buffer_pkg

/* logic/sample_buffer_status_logic.sv */
// Output sample buffer with fill count, watermark and overrun status.
`timescale 1ns/1ps
`default_nettype none

module sample_buffer_status_logic #(
    parameter int DEPTH = 32
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [7:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    input wire logic sample_valid,
    input wire logic [sample_buffer_pkg::AXIS_W-1:0] sample_x,
    input wire logic [sample_buffer_pkg::AXIS_W-1:0] sample_y,
    input wire logic [sample_buffer_pkg::AXIS_W-1:0] sample_z,
    output logic irq
);
    import sample_buffer_pkg::*;

    localparam int PW = $clog2(DEPTH);
    localparam logic [CNT_W-1:0] FULL_COUNT = CNT_W'(DEPTH);
    localparam logic [CNT_W-1:0] CNT_ONE = CNT_W'(1);
    localparam logic [PW-1:0] PTR_ONE = PW'(1);
    // Largest ring whose full count still fits the six-bit field
    localparam int MAX_DEPTH = 2 ** (CNT_W - 1);

    // ==========================================================
    // Elaboration check
    // ==========================================================
    // Count field is six bits and the ring relies on pointer wrap;
    // a depth of one would leave the pointer without any bits
    localparam bit DEPTH_OK = (DEPTH >= 2) && (DEPTH <= MAX_DEPTH)
        && ((DEPTH & (DEPTH - 1)) == 0);
    if (!DEPTH_OK) begin : g_bad
        $error("DEPTH must be a power of two from 2 to 32");
    end

    // ==========================================================
    // State record and register map
    // ==========================================================
    // Ring memory, pointer, flags and bus outputs share one record so
    // that a single register process holds the whole block.
    // Word index (byte address shifted right by two) and contents:
    //   0B status: watermark 7, overrun 6, stored count 5..0, read only
    //   12 setup first: run mode 1..0 (zero is off), read type 2
    //   13 setup second: watermark level 5..0, flush 7 (reads zero)
    //   14 data xy: x 11..0 and y 23..12 of the shown triplet
    //   15 data z: z 11..0 of the shown triplet; reading it pops
    //   16 interrupt status: watermark 0, overrun 1, write one to clear
    //   17 interrupt mask: same layout as the interrupt status
    // Any other index reads zero and ignores writes.
    typedef struct packed {
        logic [DEPTH-1:0][SAMPLE_W-1:0] mem;
        logic [PW-1:0] wr_ptr;
        logic [CNT_W-1:0] count;
        logic [MODE_W-1:0] mode;
        logic rd_type;
        logic [LEVEL_W-1:0] level;
        logic wmrk;
        logic ovf;
        logic [IRQ_W-1:0] irq_status;
        logic [IRQ_W-1:0] irq_mask;
        logic waitrequest;
        logic [31:0] readdata;
        logic irq;
    } state_s;

    state_s cur;
    state_s nxt;

    // ==========================================================
    // Helpers
    // ==========================================================
    // Slot of the sample shown to the host for the current read type.
    // When full the count wraps to zero in the pointer width, so the
    // oldest slot is then the write pointer itself.
    function automatic logic [PW-1:0] shown_slot(
        input logic [PW-1:0] ptr,
        input logic [CNT_W-1:0] cnt,
        input logic lifo
    );
        logic [PW-1:0] slot;
        if (lifo == TYPE_LIFO) begin
            slot = ptr - PTR_ONE;
        end else begin
            slot = ptr - cnt[PW-1:0];
        end
        return slot;
    endfunction : shown_slot

    // Composed status byte, forced to zero while the buffer is off;
    // all three non-zero mode codes run the buffer alike
    function automatic logic [7:0] status_byte(input state_s s);
        logic [7:0] b;
        b = 8'h00;
        if (s.mode != MODE_OFF) begin
            b[CNT_W-1:0] = s.count;
            b[ST_OVF_BIT] = s.ovf;
            b[ST_WMRK_BIT] = s.wmrk;
        end
        return b;
    endfunction : status_byte

    // ==========================================================
    // Next state
    // ==========================================================
    // Strobes of this cycle; pop, push, flush, disable_now, ovf_event and irq_clr cleared at the top of the process
    logic accept;
    logic [7:0] word_idx;
    logic [SAMPLE_W-1:0] shown;
    logic pop;
    logic push;
    logic flush;
    logic disable_now;
    logic ovf_event;
    logic wmrk_rise;
    logic [IRQ_W-1:0] irq_set;
    logic [IRQ_W-1:0] irq_clr;

    always_comb begin
        nxt = cur;
        accept = (avs_read || avs_write) && !cur.waitrequest;
        word_idx = {{WORD_SHIFT{1'b0}}, avs_address[7:WORD_SHIFT]};
        shown = cur.mem[shown_slot(cur.wr_ptr, cur.count, cur.rd_type)];
        pop = 1'b0;
        push = 1'b0;
        flush = 1'b0;
        disable_now = 1'b0;
        ovf_event = 1'b0;
        irq_clr = '0;

        // ======================================================
        // Bus handshake and read data
        // ======================================================
        // One wait cycle per access, then a single accept edge. Side
        // effects (writes, pops) act only at that edge, so a master
        // that holds its request until waitrequest drops acts once;
        // two cycles per access is both the best and the only case.
        nxt.waitrequest = 1'b1;
        if ((avs_read || avs_write) && cur.waitrequest) begin
            nxt.waitrequest = 1'b0;
        end

        // Read data prepared one cycle before the accept edge
        nxt.readdata = 32'h0000_0000;
        if (avs_read && cur.waitrequest) begin
            unique case (word_idx)
                IDX_STATUS: nxt.readdata[7:0] = status_byte(cur);
                IDX_SETUP_FIRST: begin
                    nxt.readdata[MODE_LSB +: MODE_W] = cur.mode;
                    nxt.readdata[TYPE_BIT] = cur.rd_type;
                end
                IDX_SETUP_SECOND: nxt.readdata[LEVEL_W-1:0] = cur.level;
                // Newest or oldest triplet, per read type
                IDX_DATA_XY: begin
                    nxt.readdata[2*AXIS_W-1:0] = shown[2*AXIS_W-1:0];
                end
                IDX_DATA_Z: begin
                    nxt.readdata[AXIS_W-1:0] = shown[SAMPLE_W-1:2*AXIS_W];
                end
                IDX_IRQ_STATUS: nxt.readdata[IRQ_W-1:0] = cur.irq_status;
                IDX_IRQ_MASK: nxt.readdata[IRQ_W-1:0] = cur.irq_mask;
                default: nxt.readdata = 32'h0000_0000;
            endcase
        end

        // ======================================================
        // Register writes and pops
        // ======================================================
        // Register side effects, only at the accept edge; only byte
        // lane zero carries register bits
        if (accept && avs_write && avs_byteenable[0]) begin
            unique case (word_idx)
                IDX_SETUP_FIRST: begin
                    nxt.mode = avs_writedata[MODE_LSB +: MODE_W];
                    nxt.rd_type = avs_writedata[TYPE_BIT];
                    disable_now = (nxt.mode == MODE_OFF);
                end
                IDX_SETUP_SECOND: begin
                    nxt.level = avs_writedata[LEVEL_W-1:0];
                    flush = avs_writedata[FLUSH_BIT];
                end
                IDX_IRQ_STATUS: irq_clr = avs_writedata[IRQ_W-1:0];
                IDX_IRQ_MASK: nxt.irq_mask = avs_writedata[IRQ_W-1:0];
                default: ;
            endcase
        end
        // Z word ends a complete sample readout
        if (accept && avs_read && word_idx == IDX_DATA_Z) begin
            pop = (cur.mode != MODE_OFF) && (cur.count != '0);
        end

        // ======================================================
        // Ring update
        // ======================================================
        // Pop first, then push, so a LIFO pop and push share a slot.
        // The ring never moves data: FIFO finds its oldest entry at the
        // write pointer minus the count, LIFO its newest just below the
        // pointer, so a FIFO pop needs nothing but the lower count.
        if (pop) begin
            nxt.count = nxt.count - CNT_ONE;
            if (cur.rd_type == TYPE_LIFO) begin
                nxt.wr_ptr = nxt.wr_ptr - PTR_ONE;
            end
            nxt.ovf = 1'b0;
        end
        // A triplet landing with a flush or disable is dropped, so no
        // stale sample waits for the host after the buffer restarts
        if (sample_valid && cur.mode != MODE_OFF
            && !flush && !disable_now) begin
            push = (nxt.count < FULL_COUNT);
            // Full: new triplet dropped, count held at full
            ovf_event = !push;
        end
        if (push) begin
            nxt.mem[nxt.wr_ptr] = {sample_z, sample_y, sample_x};
            nxt.wr_ptr = nxt.wr_ptr + PTR_ONE;
            nxt.count = nxt.count + CNT_ONE;
        end
        // Overrun only on a dropped triplet, never while all fit
        if (ovf_event) begin
            nxt.ovf = 1'b1;
        end

        // ======================================================
        // Flags and interrupt
        // ======================================================
        // Flush and disable empty the count and drop both flags.
        // Disabling keeps the ring contents but zeroes the count, so
        // the old triplets cannot be popped, yet the data words still read the slot the pointer selects.
        if (flush) begin
            nxt.count = '0;
            nxt.ovf = 1'b0;
        end
        if (disable_now || nxt.mode == MODE_OFF) begin
            nxt.count = '0;
            nxt.ovf = 1'b0;
        end

        // Watermark follows the count. Level zero never triggers: an
        // empty buffer at its level would interrupt after every enable.
        nxt.wmrk = (nxt.mode != MODE_OFF) && (nxt.level != '0)
            && (nxt.count >= nxt.level);
        if (flush || disable_now) begin
            nxt.wmrk = 1'b0;
        end

        // Sticky interrupt bits; a new event beats a same-cycle clear,
        // so an event landing with a write-one-clear still interrupts
        wmrk_rise = nxt.wmrk && !cur.wmrk;
        irq_set = '0;
        irq_set[IRQ_WMRK_BIT] = wmrk_rise;
        irq_set[IRQ_OVF_BIT] = ovf_event;
        nxt.irq_status = (cur.irq_status & ~irq_clr) | irq_set;
        nxt.irq = |(nxt.irq_status & nxt.irq_mask);
    end

    // ==========================================================
    // State register
    // ==========================================================
    // Reset parks the bus in its wait state with every flag at zero
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cur <= '0;
            cur.mode <= MODE_RESET;
            cur.rd_type <= TYPE_FIFO;
            cur.level <= LEVEL_RESET;
            cur.irq_mask <= IRQ_MASK_RESET;
            cur.waitrequest <= 1'b1;
        end else begin
            cur <= nxt;
        end
    end

    // Outputs straight from the state register
    assign avs_readdata = cur.readdata;
    assign avs_waitrequest = cur.waitrequest;
    assign irq = cur.irq;

endmodule : sample_buffer_status_logic

`default_nettype wire

/* sim/triplet_source.sv */
// Behavioural source of accelerometer triplets for the buffer block.
`timescale 1ns/1ps
`default_nettype none
module triplet_source (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic send,
    input wire logic [35:0] data,
    output logic sample_valid,
    output logic [11:0] sample_x,
    output logic [11:0] sample_y,
    output logic [11:0] sample_z
);
    // ==========================================================
    // Triplet launch
    // ==========================================================
    // One valid cycle per triplet; axes invert between triplets so
    // the block cannot lean on stale data
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sample_valid <= 1'b0;
            {sample_z, sample_y, sample_x} <= 36'h0;
        end else begin
            sample_valid <= send;
            {sample_z, sample_y, sample_x} <= send ? data
                : ~{sample_z, sample_y, sample_x};
        end
    end
endmodule : triplet_source
`default_nettype wire

/* sim/sample_buffer_checker.sv */
// Port-level assertions for the sample buffer status block.
`timescale 1ns/1ps
`default_nettype none
module sample_buffer_checker #(
    parameter int DEPTH = 32
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [7:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    input wire logic [31:0] avs_readdata,
    input wire logic avs_waitrequest,
    input wire logic irq
);
    import sample_buffer_pkg::*;
    // ==========================================================
    // Shadow of writable fields, taken where the write lands
    // ==========================================================
    logic [1:0] mode;
    logic [5:0] level;
    logic [1:0] mask;
    logic [7:0] idx;
    logic st_ans;
    assign idx = {2'b00, avs_address[7:2]};
    assign st_ans = avs_read && !avs_waitrequest && idx == IDX_STATUS;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            mode <= MODE_RESET;
            level <= LEVEL_RESET;
            mask <= IRQ_MASK_RESET;
        end else if (avs_write && !avs_waitrequest && avs_byteenable[0]) begin
            if (idx == IDX_SETUP_FIRST) mode <= avs_writedata[1:0];
            if (idx == IDX_SETUP_SECOND) level <= avs_writedata[5:0];
            if (idx == IDX_IRQ_MASK) mask <= avs_writedata[1:0];
        end
    end
    // ==========================================================
    // Properties; depth-2 history skips a write's settling cycle
    // ==========================================================
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    a_wait_one: assert property ((avs_read || avs_write) && avs_waitrequest
        |=> !avs_waitrequest) else $error("no answer after one wait");
    a_wait_pulse: assert property (!avs_waitrequest |=> avs_waitrequest)
        else $error("waitrequest low for more than one cycle");
    a_rdata_idle: assert property (avs_waitrequest |-> avs_readdata == 0)
        else $error("readdata not zero outside an answer");
    a_status_off: assert property (st_ans && mode == MODE_OFF
        && $past(mode, 2) == MODE_OFF |-> avs_readdata == 32'h0)
        else $error("status not zero while buffer off");
    a_count_range: assert property (st_ans |->
        avs_readdata[5:0] <= DEPTH && avs_readdata[31:8] == 24'h0)
        else $error("status count out of range");
    a_level_zero: assert property (st_ans && level == 6'h00
        && $past(level, 2) == 6'h00 |-> !avs_readdata[ST_WMRK_BIT])
        else $error("watermark set with level zero");
    a_flush_zero: assert property (avs_read && !avs_waitrequest
        && idx == IDX_SETUP_SECOND |-> !avs_readdata[FLUSH_BIT])
        else $error("flush bit reads one");
    a_irq_masked: assert property (mask == 2'h0 && $past(mask) == 2'h0
        |-> !irq) else $error("irq high with all events masked");
    c_overrun: cover property (st_ans && avs_readdata[ST_OVF_BIT]);
    c_watermark: cover property (st_ans && avs_readdata[ST_WMRK_BIT]);
    c_irq: cover property ($rose(irq));
endmodule : sample_buffer_checker
bind sample_buffer_status_logic sample_buffer_checker #(.DEPTH(DEPTH)) chk (
    .clk(clk), .rst_n(rst_n), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .irq(irq));
`default_nettype wire

/* sim/sample_buffer_status_logic_test.sv */
// Self-checking bench for the sample buffer status block.
`timescale 1ns/1ps
`default_nettype none
module sample_buffer_status_logic_test;
    import sample_buffer_pkg::*;
    // ==========================================================
    // Stimulus, reference model and reporting
    // ==========================================================
    localparam int DEP = 4;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic [7:0] avs_address = 8'h00;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0;
    logic [3:0] avs_byteenable = 4'hF;
    logic [31:0] avs_readdata;
    logic avs_waitrequest;
    logic send = 1'b0;
    logic [35:0] sdata = 36'h0;
    logic sample_valid;
    logic [11:0] sample_x, sample_y, sample_z;
    logic irq;
    int err_total = 0;
    int tests_run = 0;
    int seed = 98357;
    logic [1:0] mode = 2'h0;
    logic typ = 1'b0;
    int level = 0;
    logic ovf = 1'b0;
    logic [1:0] ist = 2'h0;
    logic [1:0] mask = 2'h0;
    logic [35:0] q[$];
    always #5 clk = ~clk;
    sample_buffer_status_logic #(.DEPTH(DEP)) uut (
        .clk(clk), .rst_n(rst_n), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .sample_valid(sample_valid), .sample_x(sample_x),
        .sample_y(sample_y), .sample_z(sample_z), .irq(irq));
    triplet_source src (.clk(clk), .rst_n(rst_n), .send(send), .data(sdata),
        .sample_valid(sample_valid), .sample_x(sample_x),
        .sample_y(sample_y), .sample_z(sample_z));
    function automatic logic wm();
        return level != 0 && q.size() >= level;
    endfunction : wm
    function automatic logic [31:0] st();
        return (mode == MODE_OFF) ? 32'h0 : {24'h0, wm(), ovf, 6'(q.size())};
    endfunction : st
    task automatic give_verdict();
        if (err_total == 0 && tests_run > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : give_verdict
    task automatic chk(input string n, input logic [31:0] e,
        input logic [31:0] g);
        tests_run++;
        if (g !== e) begin
            err_total++;
            $display("[ERR] %s expected %h seen %h", n, e, g);
        end
    endtask : chk
    // Request held until the edge that samples waitrequest low
    task automatic bus(input logic w, input logic [7:0] i,
        input logic [31:0] d, output logic [31:0] r);
        avs_address <= {i[5:0], 2'b00};
        avs_read <= !w;
        avs_write <= w;
        avs_writedata <= d;
        @(posedge clk);
        while (avs_waitrequest !== 1'b0) @(posedge clk);
        r = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        @(posedge clk);
    endtask : bus
    // Flags and irq lag their cause by a few registered stages
    task automatic rchk(input logic [7:0] i, input logic [31:0] e);
        logic [31:0] r;
        bus(1'b0, i, 32'h0, r);
        chk("register", e, r);
        repeat (2) @(posedge clk);
        chk("irq", {31'h0, |(ist & mask)}, {31'h0, irq});
    endtask : rchk
    task automatic wr(input logic [7:0] i, input logic [31:0] d);
        logic [31:0] r;
        bus(1'b1, i, d, r);
        case (avs_byteenable[0] ? i : 8'hFF)
            IDX_SETUP_FIRST: begin
                mode = d[1:0];
                typ = d[TYPE_BIT];
                if (mode == MODE_OFF) q.delete();
                if (mode == MODE_OFF) ovf = 1'b0;
            end
            IDX_SETUP_SECOND: begin
                level = d[5:0];
                if (d[FLUSH_BIT]) q.delete();
                if (d[FLUSH_BIT]) ovf = 1'b0;
            end
            IDX_IRQ_STATUS: ist = ist & ~d[1:0];
            IDX_IRQ_MASK: mask = d[1:0];
            default: ;
        endcase
    endtask : wr
    task automatic push(input int n);
        logic [63:0] v;
        logic b;
        repeat (n) begin
            v = {$random(seed), $random(seed)};
            send <= 1'b1;
            sdata <= v[35:0];
            @(posedge clk);
            send <= 1'b0;
            repeat (3) @(posedge clk);
            b = wm();
            if (mode != MODE_OFF && q.size() < DEP) q.push_back(v[35:0]);
            else if (mode != MODE_OFF) ovf = 1'b1;
            if (mode != MODE_OFF && ovf) ist[IRQ_OVF_BIT] = 1'b1;
            if (!b && wm()) ist[IRQ_WMRK_BIT] = 1'b1;
        end
    endtask : push
    task automatic pop();
        logic [35:0] s;
        s = typ ? q[$] : q[0];
        rchk(IDX_DATA_XY, {8'h0, s[23:0]});
        if (typ) void'(q.pop_back());
        else void'(q.pop_front());
        ovf = 1'b0;
        rchk(IDX_DATA_Z, {20'h0, s[35:24]});
    endtask : pop
    initial begin
        #100000;
        err_total++;
        give_verdict();
    end
    initial begin
        repeat (5) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        rchk(IDX_STATUS, st());
        push(2);
        rchk(IDX_STATUS, st());
        wr(IDX_IRQ_MASK, 32'h3);
        wr(IDX_SETUP_SECOND, 32'h3);
        wr(IDX_SETUP_FIRST, 32'h1);
        repeat (DEP + 1) begin
            push(1);
            rchk(IDX_STATUS, st());
        end
        rchk(IDX_IRQ_STATUS, {30'h0, ist});
        pop();
        rchk(IDX_STATUS, st());
        pop();
        rchk(IDX_STATUS, st());
        wr(IDX_IRQ_STATUS, 32'h3);
        wr(IDX_SETUP_FIRST, 32'h5);
        rchk(IDX_SETUP_FIRST, 32'h5);
        push(2);
        pop();
        wr(IDX_SETUP_SECOND, 32'h83);
        rchk(IDX_STATUS, st());
        rchk(IDX_SETUP_SECOND, 32'h3);
        avs_byteenable <= 4'hE;
        wr(IDX_SETUP_SECOND, 32'h85);
        avs_byteenable <= 4'hF;
        rchk(IDX_SETUP_SECOND, 32'h3);
        push(DEP + 1);
        wr(IDX_SETUP_FIRST, 32'h0);
        rchk(IDX_STATUS, st());
        wr(IDX_SETUP_FIRST, 32'h2);
        rchk(IDX_STATUS, st());
        rchk(8'h3F, 32'h0);
        // Host answers the watermark interrupt by draining everything
        wr(IDX_IRQ_STATUS, 32'h3);
        push(DEP);
        rchk(IDX_IRQ_STATUS, {30'h0, ist});
        while (q.size() > 0) pop();
        rchk(IDX_STATUS, st());
        repeat (16) begin
            if ($random(seed) & 1) push(1);
            else if (q.size() > 0) pop();
            rchk(IDX_STATUS, st());
        end
        give_verdict();
    end
endmodule : sample_buffer_status_logic_test
`default_nettype wire
